/* File: timer_pkg.sv */
// Package holding register map, field layout, reset values and types of the capture/compare timer.
package timer_pkg;

   localparam int unsigned COUNT_WIDTH = 16;
   localparam logic [15:0] COUNT_ALL_ONES = 16'hffff;

   // Byte addresses of the registers on the AXI4-Lite bus.
   localparam logic [7:0] ADDR_CONTROL_STATUS = 8'h00;
   localparam logic [7:0] ADDR_FREE_COUNT = 8'h04;
   localparam logic [7:0] ADDR_COMPARE_VALUE = 8'h08;
   localparam logic [7:0] ADDR_CAPTURED_COUNT = 8'h0c;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
   localparam logic [7:0] ADDR_PIN_CONTROL = 8'h18;
   localparam logic [7:0] ADDR_VECTOR = 8'h1c;

   // Control and status field positions.
   localparam int unsigned BIT_CAPTURE_FLAG = 7;
   localparam int unsigned BIT_MATCH_FLAG = 6;
   localparam int unsigned BIT_WRAP_FLAG = 5;
   localparam int unsigned BIT_CAPTURE_IRQ_ENABLE = 4;
   localparam int unsigned BIT_MATCH_IRQ_ENABLE = 3;
   localparam int unsigned BIT_WRAP_IRQ_ENABLE = 2;
   localparam int unsigned BIT_CAPTURE_EDGE_SELECT = 1;
   localparam int unsigned BIT_MATCH_OUTPUT_LEVEL = 0;

   // Event status and mask field positions.
   localparam int unsigned EVT_CAPTURE = 0;
   localparam int unsigned EVT_MATCH = 1;
   localparam int unsigned EVT_WRAP = 2;

   // Reset values.
   localparam logic [4:0] CONTROL_RESET = 5'h00;
   localparam logic [15:0] COMPARE_RESET = 16'hffff;
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [2:0] MASK_RESET = 3'h0;

   // Vector codes, highest priority first.
   localparam logic [1:0] VECTOR_NONE = 2'h0;
   localparam logic [1:0] VECTOR_CAPTURE = 2'h1;
   localparam logic [1:0] VECTOR_MATCH = 2'h2;
   localparam logic [1:0] VECTOR_WRAP = 2'h3;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Event flags carried together.
   typedef struct packed
   {
      logic wrap;
      logic match;
      logic capture;
   } event_type;

   // Software controls of the timer.
   typedef struct packed
   {
      logic capture_irq_enable;
      logic match_irq_enable;
      logic wrap_irq_enable;
      logic capture_edge_select;
      logic match_output_level;
   } control_type;

endpackage

/* File: capture_compare_timer.sv */
// Free-running 16-bit capture/compare timer with an AXI4-Lite register slave.
//
// Chosen here: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps

module capture_compare_timer
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic capture_pin,
   output logic match_pin_out,
   output logic match_pin_oe,
   output logic [2:0] timer_irq_request,
   output logic [1:0] timer_irq_vector,
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.

   logic [15:0] free_count;
   logic [15:0] compare_value;
   logic [15:0] captured_count;
   timer_pkg::control_type control;
   timer_pkg::event_type flags;
   timer_pkg::event_type next_event;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic match_direction_out;
   logic match_latch;
   logic capture_sync_first;
   logic capture_sync;
   logic capture_prev;
   logic edge_seen;
   logic status_read_armed;
   timer_pkg::event_type clear_armed;
   logic [7:0] aw_addr_held;
   logic aw_held;
   logic [31:0] w_data_held;
   logic [3:0] w_strb_held;
   logic w_held;
   logic write_fire;
   logic read_fire;
   timer_pkg::event_type clear_now;
   logic [31:0] next_rdata;
   logic next_rresp_bad;

   function automatic logic known_address(input logic [7:0] addr);
      known_address = (addr[1:0] == 2'h0) && (addr <= timer_pkg::ADDR_VECTOR);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Free-running counter.

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         free_count <= timer_pkg::COUNT_RESET;
      else
         free_count <= free_count + 16'h0001;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Capture input path.

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         capture_sync_first <= 1'b0;
         capture_sync <= 1'b0;
         capture_prev <= 1'b0;
      end
      else
      begin
         capture_sync_first <= capture_pin;
         capture_sync <= capture_sync_first;
         capture_prev <= capture_sync;
      end
   end

   assign edge_seen = control.capture_edge_select ? (capture_sync && !capture_prev)
                                                  : (!capture_sync && capture_prev);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         captured_count <= timer_pkg::COUNT_RESET;
      else if (edge_seen)
         captured_count <= free_count;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events and flags.

   always_comb
   begin
      next_event.capture = edge_seen;
      next_event.match = (compare_value == free_count);
      next_event.wrap = (free_count == timer_pkg::COUNT_ALL_ONES);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flags <= '0;
      else
         flags <= next_event | (flags & ~clear_now);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         match_latch <= 1'b0;
      else if (next_event.match)
         match_latch <= control.match_output_level;
   end

   assign match_pin_out = match_latch;
   assign match_pin_oe = match_direction_out;

   assign timer_irq_request = {flags.wrap && control.wrap_irq_enable,
                               flags.match && control.match_irq_enable,
                               flags.capture && control.capture_irq_enable};

   always_comb
   begin
      if (timer_irq_request[timer_pkg::EVT_CAPTURE])
         timer_irq_vector = timer_pkg::VECTOR_CAPTURE;
      else if (timer_irq_request[timer_pkg::EVT_MATCH])
         timer_irq_vector = timer_pkg::VECTOR_MATCH;
      else if (timer_irq_request[timer_pkg::EVT_WRAP])
         timer_irq_vector = timer_pkg::VECTOR_WRAP;
      else
         timer_irq_vector = timer_pkg::VECTOR_NONE;
   end

   // Sticky interrupt status, write one to clear, set wins.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         irq_status <= 3'h0;
      else if (write_fire && aw_addr_held == timer_pkg::ADDR_IRQ_STATUS && w_strb_held[0])
         irq_status <= next_event | (irq_status & ~w_data_held[2:0]);
      else
         irq_status <= next_event | irq_status;
   end

   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////////
   // Flag clearing sequence.

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         status_read_armed <= 1'b0;
         clear_armed <= '0;
      end
      else if (read_fire && s_axi_araddr == timer_pkg::ADDR_CONTROL_STATUS)
      begin
         status_read_armed <= 1'b1;
         clear_armed <= flags;
      end
   end

   always_comb
   begin
      clear_now = '0;
      if (status_read_armed)
      begin
         if (read_fire && s_axi_araddr == timer_pkg::ADDR_CAPTURED_COUNT)
            clear_now.capture = clear_armed.capture;
         if (write_fire && aw_addr_held == timer_pkg::ADDR_COMPARE_VALUE)
            clear_now.match = clear_armed.match;
         if (read_fire && s_axi_araddr == timer_pkg::ADDR_FREE_COUNT)
            clear_now.wrap = clear_armed.wrap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel.

   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign write_fire = aw_held && w_held && !s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr_held <= 8'h00;
         w_data_held <= 32'h0000_0000;
         w_strb_held <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= timer_pkg::RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr_held <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data_held <= s_axi_wdata;
            w_strb_held <= s_axi_wstrb;
         end
         if (write_fire)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= known_address(aw_addr_held) ? timer_pkg::RESP_OKAY
                                                       : timer_pkg::RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // Writable registers.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         control <= timer_pkg::CONTROL_RESET;
         compare_value <= timer_pkg::COMPARE_RESET;
         irq_mask <= timer_pkg::MASK_RESET;
         match_direction_out <= 1'b0;
      end
      else if (write_fire)
      begin
         case (aw_addr_held)
            timer_pkg::ADDR_CONTROL_STATUS:
               if (w_strb_held[0])
                  control <= w_data_held[4:0];
            timer_pkg::ADDR_COMPARE_VALUE:
            begin
               if (w_strb_held[0])
                  compare_value[7:0] <= w_data_held[7:0];
               if (w_strb_held[1])
                  compare_value[15:8] <= w_data_held[15:8];
            end
            timer_pkg::ADDR_IRQ_MASK:
               if (w_strb_held[0])
                  irq_mask <= w_data_held[2:0];
            timer_pkg::ADDR_PIN_CONTROL:
               if (w_strb_held[0])
                  match_direction_out <= w_data_held[0];
            default:
               ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel.

   assign s_axi_arready = !s_axi_rvalid;
   assign read_fire = s_axi_arvalid && s_axi_arready;

   always_comb
   begin
      next_rdata = 32'h0000_0000;
      next_rresp_bad = 1'b0;
      case (s_axi_araddr)
         timer_pkg::ADDR_CONTROL_STATUS:
            next_rdata[7:0] = {flags.capture, flags.match, flags.wrap, control};
         timer_pkg::ADDR_FREE_COUNT:
            next_rdata[15:0] = free_count;
         timer_pkg::ADDR_COMPARE_VALUE:
            next_rdata[15:0] = compare_value;
         timer_pkg::ADDR_CAPTURED_COUNT:
            next_rdata[15:0] = captured_count;
         timer_pkg::ADDR_IRQ_STATUS:
            next_rdata[2:0] = irq_status;
         timer_pkg::ADDR_IRQ_MASK:
            next_rdata[2:0] = irq_mask;
         timer_pkg::ADDR_PIN_CONTROL:
            next_rdata[0] = match_direction_out;
         timer_pkg::ADDR_VECTOR:
            next_rdata[1:0] = timer_irq_vector;
         default:
            next_rresp_bad = 1'b1;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= timer_pkg::RESP_OKAY;
      end
      else if (read_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp_bad ? timer_pkg::RESP_SLVERR : timer_pkg::RESP_OKAY;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   property p_count_step;
      @(posedge aclk) disable iff (!aresetn)
      $past(aresetn) |-> free_count == $past(free_count) + 16'h0001;
   endproperty
   a_count_step: assert property (p_count_step) else $error("Count did not step.");

   property p_wrap_set;
      @(posedge aclk) disable iff (!aresetn)
      free_count == timer_pkg::COUNT_ALL_ONES |=> flags.wrap;
   endproperty
   a_wrap_set: assert property (p_wrap_set) else $error("Wrap flag not set.");

   property p_capture_copy;
      @(posedge aclk) disable iff (!aresetn)
      edge_seen |=> captured_count == $past(free_count) && flags.capture;
   endproperty
   a_capture_copy: assert property (p_capture_copy) else $error("Capture failed.");

   property p_rise_edge;
      @(posedge aclk) disable iff (!aresetn)
      edge_seen == (control.capture_edge_select ? $rose(capture_sync) : $fell(capture_sync));
   endproperty
   a_rise_edge: assert property (p_rise_edge) else $error("Rising edge missed.");

   property p_capture_flag_cause;
      @(posedge aclk) disable iff (!aresetn)
      $rose(flags.capture) |-> $past(edge_seen);
   endproperty
   a_capture_flag_cause: assert property (p_capture_flag_cause) else $error("Stray capture.");

   property p_match_set;
      @(posedge aclk) disable iff (!aresetn)
      compare_value == free_count |=> flags.match;
   endproperty
   a_match_set: assert property (p_match_set) else $error("Match flag not set.");

   property p_latch_level;
      @(posedge aclk) disable iff (!aresetn)
      next_event.match |=> match_latch == $past(control.match_output_level);
   endproperty
   a_latch_level: assert property (p_latch_level) else $error("Latch level wrong.");

   property p_pin_enable;
      @(posedge aclk) disable iff (!aresetn)
      write_fire && aw_addr_held == timer_pkg::ADDR_PIN_CONTROL && w_strb_held[0]
         |=> match_pin_oe == $past(w_data_held[0]) && match_pin_out == match_latch;
   endproperty
   a_pin_enable: assert property (p_pin_enable) else $error("Pin drive wrong.");

   property p_request_gate;
      @(posedge aclk) disable iff (!aresetn)
      timer_irq_request[0] == (flags.capture && control.capture_irq_enable);
   endproperty
   a_request_gate: assert property (p_request_gate) else $error("Request gate wrong.");

   property p_priority;
      @(posedge aclk) disable iff (!aresetn)
      timer_irq_request[0] |-> timer_irq_vector == timer_pkg::VECTOR_CAPTURE;
   endproperty
   a_priority: assert property (p_priority) else $error("Priority wrong.");

endmodule

/* File: pin_side_model.sv */
// Pin-side partner model: drives the capture input and resolves the compare output pin.
`timescale 1ns/1ps
module pin_side_model
(
   input wire logic aclk,
   input wire logic capture_level,
   input wire logic match_pin_out,
   input wire logic match_pin_oe,
   output logic capture_pin,
   output logic match_wire
);
   ////////////////////////////////////////////////////////////////////////////////
   // single input pin.
   always @(posedge aclk)
   begin
      capture_pin <= capture_level;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // pull-up when released.
   assign match_wire = match_pin_oe ? match_pin_out : 1'b1;
endmodule

/* File: tb_capture_compare_timer.sv */
// Testbench of the capture/compare timer through its register bus and pins.
`timescale 1ns/1ps
module tb_capture_compare_timer;
   logic aclk;
   logic aresetn;
   logic [7:0] s_axi_awaddr;
   logic s_axi_awvalid;
   logic s_axi_awready;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   logic s_axi_wvalid;
   logic s_axi_wready;
   logic [1:0] s_axi_bresp;
   logic s_axi_bvalid;
   logic s_axi_bready;
   logic [7:0] s_axi_araddr;
   logic s_axi_arvalid;
   logic s_axi_arready;
   logic [31:0] s_axi_rdata;
   logic [1:0] s_axi_rresp;
   logic s_axi_rvalid;
   logic s_axi_rready;
   logic capture_pin;
   logic match_pin_out;
   logic match_pin_oe;
   logic [2:0] timer_irq_request;
   logic [1:0] timer_irq_vector;
   logic irq;
   logic capture_level;
   logic match_wire;
   logic [1:0] resp;
   logic [31:0] rd;
   logic [15:0] first;
   int error_cnt;
   int checks_done;
   int cyc = 0;
   int stamp;
   int t0;
   int raise;
   int k;

   capture_compare_timer capture_compare_timer_inst
   (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_pin, .match_pin_out,
      .match_pin_oe, .timer_irq_request, .timer_irq_vector, .irq
   );

   pin_side_model pin_side_model_inst
   (
      .aclk, .capture_level, .match_pin_out, .match_pin_oe, .capture_pin, .match_wire
   );

   initial
   begin
      aclk = 1'b0;
      forever #20 aclk = ~aclk;
   end

   always @(posedge aclk) cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask

   task automatic give_up(input string what);
      $display("wrong value %s expected answer seen timeout", what);
      error_cnt++;
      final_report();
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_hs;
      logic w_hs;
      logic b_hs;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      b_hs = 1'b0;
      for (int n = 0; n < 50 && !b_hs; n++)
      begin
         @(negedge aclk);
         aw_hs = s_axi_awvalid && s_axi_awready;
         w_hs = s_axi_wvalid && s_axi_wready;
         b_hs = s_axi_bvalid && s_axi_bready;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (aw_hs)
            s_axi_awvalid <= 1'b0;
         if (w_hs)
            s_axi_wvalid <= 1'b0;
         if (b_hs)
            s_axi_bready <= 1'b0;
      end
      if (!b_hs)
         give_up("write response");
   endtask

   task automatic axi_read(input logic [7:0] a);
      logic ar_hs;
      logic r_hs;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r_hs = 1'b0;
      for (int n = 0; n < 50 && !r_hs; n++)
      begin
         @(negedge aclk);
         ar_hs = s_axi_arvalid && s_axi_arready;
         if (ar_hs)
            stamp = cyc;
         r_hs = s_axi_rvalid && s_axi_rready;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ar_hs)
            s_axi_arvalid <= 1'b0;
         if (r_hs)
            s_axi_rready <= 1'b0;
      end
      if (!r_hs)
         give_up("read data");
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string what);
      axi_read(a);
      check(what, e, rd);
   endtask

   task automatic set_pin(input logic v);
      @(posedge aclk);
      capture_level <= v;
      raise = cyc;
      repeat (10) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
      {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
      capture_level = 1'b0;
      aresetn = 1'b0;
      error_cnt = 0;
      checks_done = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values of the register map.
      rchk(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_0000, "control");
      rchk(timer_pkg::ADDR_COMPARE_VALUE, 32'h0000_ffff, "compare");
      rchk(timer_pkg::ADDR_IRQ_MASK, 32'h0000_0000, "mask");
      rchk(timer_pkg::ADDR_VECTOR, 32'(timer_pkg::VECTOR_NONE), "vector reg");
      check("irq", 32'h0000_0000, 32'(irq));
      // Running count advances once per clock.
      axi_read(timer_pkg::ADDR_FREE_COUNT);
      first = rd[15:0];
      t0 = stamp;
      axi_read(timer_pkg::ADDR_FREE_COUNT);
      check("count step", {16'h0000, first + 16'(stamp - t0)}, rd);
      // Unmapped place is refused.
      axi_read(8'h20);
      check("read resp", 32'(timer_pkg::RESP_SLVERR), 32'(resp));
      axi_write(8'h20, 32'h0000_00ff, 4'h1);
      check("write resp", 32'(timer_pkg::RESP_SLVERR), 32'(resp));
      // Capture on rising edge, then on falling edge, with the match pin set as output.
      axi_write(timer_pkg::ADDR_PIN_CONTROL, 32'h0000_0001, 4'h1);
      axi_write(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_001e, 4'h1);
      axi_read(timer_pkg::ADDR_FREE_COUNT);
      first = rd[15:0];
      t0 = stamp;
      set_pin(1'b1);
      check("capture req", 32'h0000_0001, 32'(timer_irq_request[0]));
      check("vector", 32'(timer_pkg::VECTOR_CAPTURE), 32'(timer_irq_vector));
      rchk(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_009e, "status");
      axi_read(timer_pkg::ADDR_CAPTURED_COUNT);
      k = int'(16'(rd[15:0] - first)) - (raise - t0);
      check("capture delay", 32'h0000_0001, 32'(k >= 2 && k <= 8));
      check("capture clear", 32'h0000_0000, 32'(timer_irq_request[0]));
      set_pin(1'b0);
      check("no falling", 32'h0000_0000, 32'(timer_irq_request[0]));
      axi_write(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_001c, 4'h1);
      set_pin(1'b1);
      check("no rising", 32'h0000_0000, 32'(timer_irq_request[0]));
      set_pin(1'b0);
      check("falling", 32'h0000_0001, 32'(timer_irq_request[0]));
      // Compare match copies the level bit into the output latch.
      for (int i = 1; i >= 0; i--)
      begin
         axi_write(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_001c | 32'(i), 4'h1);
         axi_read(timer_pkg::ADDR_FREE_COUNT);
         axi_write(timer_pkg::ADDR_COMPARE_VALUE, {16'h0000, rd[15:0] + 16'h00c8}, 4'h3);
         check("pin held", 32'(1 - i), 32'(match_pin_out));
         for (k = 0; k < 400 && match_pin_out !== i[0]; k++)
            @(posedge aclk);
         check("match time", 32'h0000_0001, 32'(k > 150 && k < 210));
         check("match req", 32'h0000_0001, 32'(timer_irq_request[1]));
         check("pin wire", 32'(i), 32'(match_wire));
      end
      axi_write(timer_pkg::ADDR_PIN_CONTROL, 32'h0000_0000, 4'h1);
      check("pin enable", 32'h0000_0000, 32'(match_pin_oe));
      check("pin released", 32'h0000_0001, 32'(match_wire));
      // Wrap flag at all ones, then priority of the vectors.
      for (k = 0; k < 70000 && timer_irq_request[2] !== 1'b1; k++)
         @(posedge aclk);
      if (k >= 70000)
         give_up("wrap flag");
      axi_read(timer_pkg::ADDR_FREE_COUNT);
      check("count at wrap", 32'h0000_0001, 32'(rd[15:0] < 16'h0010));
      check("vector", 32'(timer_pkg::VECTOR_CAPTURE), 32'(timer_irq_vector));
      rchk(timer_pkg::ADDR_CONTROL_STATUS, 32'h0000_00fc, "all flags");
      axi_read(timer_pkg::ADDR_CAPTURED_COUNT);
      check("vector", 32'(timer_pkg::VECTOR_MATCH), 32'(timer_irq_vector));
      axi_write(timer_pkg::ADDR_COMPARE_VALUE, 32'h0000_8000, 4'h3);
      check("vector", 32'(timer_pkg::VECTOR_WRAP), 32'(timer_irq_vector));
      axi_read(timer_pkg::ADDR_FREE_COUNT);
      check("vector", 32'(timer_pkg::VECTOR_NONE), 32'(timer_irq_vector));
      check("requests", 32'h0000_0000, 32'(timer_irq_request));
      // Sticky status, mask and the interrupt line.
      rchk(timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0007, "irq status");
      axi_write(timer_pkg::ADDR_IRQ_MASK, 32'h0000_0001, 4'h1);
      check("irq", 32'h0000_0001, 32'(irq));
      axi_write(timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0001, 4'h1);
      check("irq", 32'h0000_0000, 32'(irq));
      rchk(timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0006, "irq status");
      axi_write(timer_pkg::ADDR_IRQ_MASK, 32'h0000_0006, 4'h1);
      check("irq", 32'h0000_0001, 32'(irq));
      axi_write(timer_pkg::ADDR_IRQ_STATUS, 32'h0000_0006, 4'h1);
      check("irq", 32'h0000_0000, 32'(irq));
      final_report();
   end
endmodule
